/* File: mrb_pkg.sv */
/*
 mode-register bank shared constants: register addresses, field layout,
 link command codes, timing counts and the controller's own register map.
 assumes sys_clk at 25 MHz on both ends.
*/
`default_nettype none
package mrb_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int AUTO_INIT_MAX_NS = 10000;
    localparam int POST_RESET_WAIT_NS = 1000;
    // longest time rounds down, least time rounds up
    localparam int AUTO_INIT_CYCLES = AUTO_INIT_MAX_NS / CLK_PERIOD_NS;
    localparam int POST_RESET_CYCLES = (POST_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // link clock: 8 sys_clk cycles, high while phase 0..3
    localparam logic [2:0] PH_RISE = 3'h7;
    localparam logic [2:0] PH_FALL = 3'h3;

    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_REGISTER_READ = 2'h1;
    localparam logic [1:0] CMD_REGISTER_WRITE = 2'h2;
    localparam int SYNC_W = 20;

    localparam logic [7:0] ADDR_DEVICE_INFO = 8'h00;
    localparam logic [7:0] ADDR_BURST_FEATURE = 8'h01;
    localparam logic [7:0] ADDR_LATENCY = 8'h02;
    localparam logic [7:0] ADDR_IO_DRIVE = 8'h03;
    localparam logic [7:0] ADDR_REFRESH_RATE = 8'h04;
    localparam logic [7:0] ADDR_MAKER_CODE = 8'h05;
    localparam logic [7:0] ADDR_REVISION_A = 8'h06;
    localparam logic [7:0] ADDR_REVISION_B = 8'h07;
    localparam logic [7:0] ADDR_GEOMETRY = 8'h08;
    localparam logic [7:0] ADDR_TEST_MODE = 8'h09;
    localparam logic [7:0] ADDR_IO_CAL = 8'h0a;
    localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
    localparam logic [7:0] ADDR_SEGMENT_MASK = 8'h11;
    localparam logic [7:0] ADDR_TRAIN_A = 8'h20;
    localparam logic [7:0] ADDR_TRAIN_B = 8'h28;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h3f;

    localparam logic [7:0] BURST_FEATURE_RST = 8'h02;
    localparam logic [7:0] LATENCY_RST = 8'h00;
    localparam logic [7:0] IO_DRIVE_RST = 8'h00;
    localparam logic [7:0] LATENCY_MASK = 8'h0f;
    localparam logic [7:0] IO_DRIVE_MASK = 8'h0f;
    localparam logic [7:0] CAL_INIT_CODE = 8'hff;
    localparam logic [1:0] SELFTEST_PASS = 2'h3;
    localparam logic [7:0] TRAIN_A_VALUE = 8'h55;
    localparam logic [7:0] TRAIN_B_VALUE = 8'h33;

    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CKE = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic addr_refused(input logic [7:0] a, input logic wr);
        logic dnu;
        logic rsv;
        dnu = (a >= 8'h14 && a <= 8'h1f) || (a >= 8'h21 && a <= 8'h27)
            || (a >= 8'h29 && a <= 8'h2f) || a == 8'h7f || a == 8'hbf || a == 8'hff;
        rsv = (a >= 8'h0b && a <= 8'h0f) || a == 8'h12 || a == 8'h13
            || (a >= 8'h30 && a <= 8'h3e) || (a >= 8'h40 && a <= 8'h7e)
            || (a >= 8'h80 && a <= 8'hbe) || (a >= 8'hc0 && a <= 8'hfe);
        return dnu || (wr && rsv);
    endfunction : addr_refused
endpackage : mrb_pkg
`default_nettype wire

/* File: mrb_link_if.sv */
/*
 command/address link between controller and mode-register device.
 assumes the bench joins both modports; dq is resolved here from the enables.
*/
`timescale 1ns/100ps
`default_nettype none
interface mrb_link_if;
    logic link_clk;
    logic cke;
    logic [1:0] cmd;
    logic [7:0] sel_addr;
    logic [7:0] ctl_dq;
    logic ctl_dq_oe;
    logic [7:0] dev_dq;
    logic dev_dq_oe;
    logic [7:0] dq;

    // no driver reads as zero
    assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : 8'h00);

    modport ctl_mp (
        output link_clk,
        output cke,
        output cmd,
        output sel_addr,
        output ctl_dq,
        output ctl_dq_oe,
        input dq
    );
    modport dev_mp (
        input link_clk,
        input cke,
        input cmd,
        input sel_addr,
        input dq,
        output dev_dq,
        output dev_dq_oe
    );
endinterface : mrb_link_if
`default_nettype wire

/* File: mrb_device.sv */
/*
 mode-register bank of the memory device: samples the link, decodes
 register read and write commands, holds settings, auto-init status.
 assumes the controller makes link_clk and changes cmd, address and data on its falling edge.
*/
//
// Operation
// - controller restarts init at reset step
// - controller holds cke low during power-off
// - outputs released while cke low
// - registers reached only by read/write commands
// - each register has one access class
// - 00h read-only device information fields
// - 01h write-only burst feature fields
// - 02h write-only latency select
// - 03h write-only driver strength
// - 04h readable temp flag and rate
// - 05h-07h read-only identification codes
// - 08h read-only width, density, type
// - 0Ah write-only calibration command code
// - 10h/11h write-only refresh masks
// - 20h/28h read-only training patterns
// - controller never writes reserved addresses
// - controller never accesses do-not-use addresses
// - controller waits after reset with nops
// - auto-init status clears within 10 us
// - reserved bits read as zero
// - writes to read-only registers ignored
`timescale 1ns/100ps
`default_nettype none
module mrb_device #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] REVISION_A = 8'h01, // arbitrary value
    parameter logic [7:0] REVISION_B = 8'h02, // arbitrary value
    parameter logic [7:0] GEOMETRY = 8'h14 // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    mrb_link_if.dev_mp link,
    input wire logic [2:0] refresh_rate,
    output logic [7:0] burst_feature_cfg,
    output logic [7:0] latency_cfg,
    output logic [7:0] io_drive_cfg,
    output logic [7:0] test_mode_select,
    output logic [7:0] io_calibration_cmd,
    output logic [7:0] refresh_bank_mask,
    output logic [7:0] refresh_segment_mask,
    output logic calib_start,
    output logic auto_init_status
);
    import mrb_pkg::*;

    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] lvl;
    logic clk_q;
    logic rise;
    logic cke_l;
    logic [1:0] cmd_l;
    logic [7:0] addr_l;
    logic [7:0] dq_l;
    logic take_wr;
    logic take_rd;
    logic soft_rst;
    logic [CNT_W-1:0] init_cnt;
    logic [1:0] calib_pin_selftest;
    logic [2:0] rate_q;
    logic temp_update_flag;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic oe_q;

    // link pins come from another domain: three stages, settle on agreement
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= {link.link_clk, link.cke, link.cmd, link.sel_addr, link.dq};
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lvl <= '0;
            clk_q <= 1'b0;
        end else begin
            lvl <= (s3 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));
            clk_q <= lvl[SYNC_W-1];
        end
    end

    assign rise = lvl[SYNC_W-1] & ~clk_q;
    assign cke_l = lvl[SYNC_W-2];
    assign cmd_l = lvl[17:16];
    assign addr_l = lvl[15:8];
    assign dq_l = lvl[7:0];

    // commands count only on a link rising edge with cke high
    assign take_wr = rise & cke_l & (cmd_l == CMD_REGISTER_WRITE);
    assign take_rd = rise & cke_l & (cmd_l == CMD_REGISTER_READ);
    assign soft_rst = take_wr & (addr_l == ADDR_SOFT_RESET);

    // settings: writes to read-only or unknown addresses fall through untouched
    always_ff @(posedge sys_clk) begin
        if (!rst_b || soft_rst) begin
            burst_feature_cfg <= BURST_FEATURE_RST;
            latency_cfg <= LATENCY_RST;
            io_drive_cfg <= IO_DRIVE_RST;
            test_mode_select <= 8'h00;
            io_calibration_cmd <= 8'h00;
            refresh_bank_mask <= 8'h00;
            refresh_segment_mask <= 8'h00;
        end else if (take_wr) begin
            unique case (addr_l)
                ADDR_BURST_FEATURE: burst_feature_cfg <= dq_l;
                ADDR_LATENCY: latency_cfg <= dq_l & LATENCY_MASK;
                ADDR_IO_DRIVE: io_drive_cfg <= dq_l & IO_DRIVE_MASK;
                ADDR_TEST_MODE: test_mode_select <= dq_l;
                ADDR_IO_CAL: io_calibration_cmd <= dq_l;
                ADDR_BANK_MASK: refresh_bank_mask <= dq_l;
                ADDR_SEGMENT_MASK: refresh_segment_mask <= dq_l;
                default: begin
                    // read-only, reserved or do-not-use: no effect
                end
            endcase
        end
    end

    // calibration pulse; a full init code also marks the pin self-test done
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            calib_start <= 1'b0;
            calib_pin_selftest <= 2'h0;
        end else begin
            calib_start <= take_wr & (addr_l == ADDR_IO_CAL);
            if (take_wr && addr_l == ADDR_IO_CAL && dq_l == CAL_INIT_CODE) begin
                calib_pin_selftest <= SELFTEST_PASS;
            end
        end
    end

    // auto-init runs after power-up and after every reset command
    always_ff @(posedge sys_clk) begin
        if (!rst_b || soft_rst) begin
            auto_init_status <= 1'b1;
            init_cnt <= '0;
        end else if (auto_init_status) begin
            if (init_cnt == CNT_W'(AUTO_INIT_CYCLES - 1)) begin
                auto_init_status <= 1'b0;
            end else begin
                init_cnt <= init_cnt + 1'b1;
            end
        end
    end

    // rate change raises the flag; a read of the rate register clears it,
    // but a change in the same cycle keeps it set
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rate_q <= 3'h0;
            temp_update_flag <= 1'b0;
        end else begin
            rate_q <= refresh_rate;
            if (rate_q != refresh_rate) begin
                temp_update_flag <= 1'b1;
            end else if (take_rd && addr_l == ADDR_REFRESH_RATE) begin
                temp_update_flag <= 1'b0;
            end
        end
    end

    // only readable registers answer; write-only and reserved read as zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_l)
            ADDR_DEVICE_INFO: begin
                next_rdata = {3'h0, calib_pin_selftest, 2'h0, auto_init_status};
            end
            ADDR_REFRESH_RATE: next_rdata = {temp_update_flag, 4'h0, rate_q};
            ADDR_MAKER_CODE: next_rdata = MAKER_CODE;
            ADDR_REVISION_A: next_rdata = REVISION_A;
            ADDR_REVISION_B: next_rdata = REVISION_B;
            ADDR_GEOMETRY: next_rdata = GEOMETRY;
            ADDR_TRAIN_A: next_rdata = TRAIN_A_VALUE;
            ADDR_TRAIN_B: next_rdata = TRAIN_B_VALUE;
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data stands one link period, dropped at the next rising edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
            oe_q <= 1'b0;
        end else if (!cke_l) begin
            oe_q <= 1'b0;
        end else if (take_rd) begin
            rdata <= next_rdata;
            oe_q <= 1'b1;
        end else if (rise) begin
            oe_q <= 1'b0;
        end
    end

    assign link.dev_dq = rdata;
    // raw cke gates the driver so the pins let go at once, not after sync
    assign link.dev_dq_oe = oe_q & link.cke;
endmodule : mrb_device
`default_nettype wire

/* File: mrb_controller.sv */
/*
 memory controller end of the mode-register link with an AXI4-Lite slave.
 assumes software writes CMD to launch one register access at a time.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module mrb_controller (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [mrb_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mrb_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    mrb_link_if.ctl_mp link
);
    import mrb_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RDWAIT, ST_RSTWAIT} mrb_ctl_state_t;
    mrb_ctl_state_t state;
    logic [2:0] ph;
    logic fall;
    logic wr_fire;
    logic ar_fire;
    logic go;
    logic launch;
    logic bad;
    logic [7:0] sel_addr_r;
    logic [7:0] wdat_r;
    logic is_wr;
    logic cke_en;
    logic refused;
    logic [7:0] rd_data;
    logic [CNT_W-1:0] wait_cnt;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] dq_l;

    // link clock is made here by dividing sys_clk by eight
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ph <= 3'h0;
            link.link_clk <= 1'b0;
        end else begin
            ph <= ph + 1'b1;
            if (ph == PH_RISE) begin
                link.link_clk <= 1'b1;
            end else if (ph == PH_FALL) begin
                link.link_clk <= 1'b0;
            end
        end
    end
    assign fall = (ph == PH_FALL);

    assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign ar_fire = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign launch = go & fall & (state == ST_IDLE);
    assign bad = addr_refused(sel_addr_r, is_wr) | ~cke_en;

    // command register; a write while busy is dropped and still answered
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sel_addr_r <= 8'h00;
            wdat_r <= 8'h00;
            is_wr <= 1'b0;
            cke_en <= 1'b0;
            go <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (launch) begin
                go <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                unique case (s_axi_awaddr)
                    REG_CMD: begin
                        if (!go && state == ST_IDLE) begin
                            if (s_axi_wstrb[0]) sel_addr_r <= s_axi_wdata[7:0];
                            if (s_axi_wstrb[1]) wdat_r <= s_axi_wdata[15:8];
                            if (s_axi_wstrb[2]) is_wr <= s_axi_wdata[16];
                            go <= 1'b1;
                        end
                    end
                    REG_CKE: begin
                        if (s_axi_wstrb[0]) cke_en <= s_axi_wdata[0];
                    end
                    REG_STATUS: begin
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CMD: s_axi_rdata <= {15'h0, is_wr, wdat_r, sel_addr_r};
                REG_STATUS: s_axi_rdata <= {16'h0, rd_data, 5'h0, link.cke, refused,
                    (state != ST_IDLE) | go};
                REG_CKE: s_axi_rdata <= {31'h0, cke_en};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // returned data crosses from the link: three stages, settle on agreement
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            d1 <= 8'h00;
            d2 <= 8'h00;
            d3 <= 8'h00;
            dq_l <= 8'h00;
        end else begin
            d1 <= link.dq;
            d2 <= d1;
            d3 <= d2;
            dq_l <= (d3 & ~(d2 ^ d3)) | (dq_l & (d2 ^ d3));
        end
    end

    // link sequencer: cmd, address and data change on the falling point, held one period; cke follows cke_en while idle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            link.cmd <= CMD_NOP;
            link.sel_addr <= 8'h00;
            link.ctl_dq <= 8'h00;
            link.ctl_dq_oe <= 1'b0;
            link.cke <= 1'b0;
            refused <= 1'b0;
            rd_data <= 8'h00;
            wait_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (!go) begin
                        link.cke <= cke_en;
                    end
                    if (launch && bad) begin
                        refused <= 1'b1;
                    end else if (launch) begin
                        refused <= 1'b0;
                        link.cmd <= is_wr ? CMD_REGISTER_WRITE : CMD_REGISTER_READ;
                        link.sel_addr <= sel_addr_r;
                        link.ctl_dq <= wdat_r;
                        link.ctl_dq_oe <= is_wr;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (fall) begin
                        link.cmd <= CMD_NOP;
                        link.ctl_dq_oe <= 1'b0;
                        wait_cnt <= '0;
                        if (!is_wr) begin
                            state <= ST_RDWAIT;
                        end else if (sel_addr_r == ADDR_SOFT_RESET) begin
                            state <= ST_RSTWAIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_RDWAIT: begin
                    if (fall) begin
                        rd_data <= dq_l;
                        state <= ST_IDLE;
                    end
                end
                ST_RSTWAIT: begin
                    // cke stays high and only nops go out meanwhile
                    if (wait_cnt == CNT_W'(POST_RESET_CYCLES - 1)) begin
                        state <= ST_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : mrb_controller
`default_nettype wire

/* File: mrb_link_assertions.sv */
/* link checker: timing and address rules on the mode-register link.
 assumes one sys_clk domain, instanced beside the link. */
`timescale 1ns/100ps
`default_nettype none
module mrb_link_assertions (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic cke,
    input wire logic [1:0] cmd,
    input wire logic [7:0] sel_addr,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe
);
    import mrb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic wr3f;
    logic wr3f_q;
    logic [4:0] gap;
    assign wr3f = cmd == CMD_REGISTER_WRITE && sel_addr == ADDR_SOFT_RESET;
    always_ff @(posedge sys_clk) begin
        wr3f_q <= rst_b && wr3f;
    end
    // counts the quiet cycles that follow the reset write
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gap <= 5'h0;
        end else if (wr3f_q && !wr3f) begin
            gap <= 5'h1;
        end else if (gap != 5'h0 && gap < 5'h18) begin
            gap <= gap + 5'h1;
        end else begin
            gap <= 5'h0;
        end
    end
    a_link_clk_shape: assert property ($rose(link_clk) |=> link_clk[*3] ##1 !link_clk[*4])
        else $error("link clock not four high, four low");
    a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(link_clk))
        else $error("command changed off the falling point");
    a_cmd_hold: assert property ($changed(cmd) |=> $stable({cmd, sel_addr})[*7])
        else $error("command not held one link period");
    a_wr_data_out: assert property (cmd == CMD_REGISTER_WRITE |-> ctl_dq_oe)
        else $error("write without data drive");
    a_no_rsv_write: assert property (cmd == CMD_REGISTER_WRITE |-> !(sel_addr inside
        {[8'h0b:8'h0f], [8'h12:8'h13], [8'h30:8'h3e], [8'h40:8'h7e]}))
        else $error("write to reserved address");
    a_no_dnu_use: assert property (cmd != CMD_NOP |-> !(sel_addr inside
        {[8'h14:8'h1f], [8'h21:8'h27], [8'h29:8'h2f], 8'h7f, 8'hbf, 8'hff}))
        else $error("access to do-not-use address");
    a_cmd_needs_cke: assert property (cmd != CMD_NOP |-> cke)
        else $error("command sent with cke low");
    a_oe_needs_cke: assert property (dev_dq_oe |-> cke && !ctl_dq_oe)
        else $error("device drives out of turn");
    a_post_rst_quiet: assert property (gap != 5'h0 |-> cmd == CMD_NOP && cke)
        else $error("traffic too soon after reset write");
endmodule : mrb_link_assertions
`default_nettype wire

/* File: sdram_mode_register_map_tb.sv */
/* bench: controller and device joined by the link, driven over AXI4-Lite.
 assumes the package constants and a 25 MHz sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module sdram_mode_register_map_tb;
    import mrb_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ais, cal;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg [7];
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [2:0] rate = 3'h0;
    logic [7:0] wa [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h10, 8'h11};
    logic [7:0] wm [7] = '{8'hff, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] ra [7] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
    logic [7:0] re [7] = '{8'h00, 8'h5a, 8'h01, 8'h02, 8'h14, 8'h55, 8'h33};
    logic [8:0] bad [8] = '{9'h10b, 9'h113, 9'h13e, 9'h17e, 9'h014, 9'h027, 9'h0bf, 9'h0ff};
    int err_count = 0, comparisons = 0, n, ncal = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cal === 1'b1) ncal++;
    mrb_link_if mrb_link_if_i ();
    mrb_controller mrb_controller_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .link(mrb_link_if_i));
    mrb_device mrb_device_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(mrb_link_if_i),
        .refresh_rate(rate), .burst_feature_cfg(cfg[0]), .latency_cfg(cfg[1]),
        .io_drive_cfg(cfg[2]), .test_mode_select(cfg[3]), .io_calibration_cmd(cfg[4]),
        .refresh_bank_mask(cfg[5]), .refresh_segment_mask(cfg[6]), .calib_start(cal),
        .auto_init_status(ais));
    mrb_link_assertions mrb_link_assertions_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .link_clk(mrb_link_if_i.link_clk), .cke(mrb_link_if_i.cke), .cmd(mrb_link_if_i.cmd),
        .sel_addr(mrb_link_if_i.sel_addr), .ctl_dq_oe(mrb_link_if_i.ctl_dq_oe),
        .dev_dq_oe(mrb_link_if_i.dev_dq_oe));
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task chk(input logic ok, input string m);
        comparisons++;
        if (!ok) begin
            err_count++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask : chk
    task lim(input int k);
        if (k >= 300) begin
            err_count++;
            final_report();
        end
    endtask : lim
    // bready and rready stay high, so each answer lasts one cycle
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid} <= 2'b11;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!(awready && wready) && n < 300);
        lim(n);
        {awvalid, wvalid} <= 2'b00;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!bvalid && n < 300);
        lim(n);
        chk(bresp === r, "write response");
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!arready && n < 300);
        lim(n);
        arvalid <= 1'b0;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!rvalid && n < 300);
        lim(n);
        rd = rdata;
        chk(rresp === r, "read response");
    endtask : axi_rd
    // one link access, then status polled until idle; status left in rd
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        axi_wr(REG_CMD, {15'h0, w, d, a}, RESP_OKAY);
        for (k = 0; k < 300; k++) begin
            axi_rd(REG_STATUS, RESP_OKAY);
            if (rd[0] === 1'b0) break;
        end
        lim(k);
    endtask : op
    task automatic after_reset;
        int k;
        chk(ais === 1'b1, "init not in progress");
        for (k = 0; k < 7; k++) chk(cfg[k] === (k == 0 ? 8'h02 : 8'h00), "reset value");
        k = 0;
        do begin @(posedge sys_clk); k++; end while (ais !== 1'b0 && k < 300);
        chk(k <= AUTO_INIT_CYCLES, "auto init late");
    endtask : after_reset
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        after_reset();
        op(1'b0, ADDR_DEVICE_INFO, 8'h00);
        chk(rd[2:1] === 2'b01, "launch with cke off");
        axi_wr(REG_CKE, 32'h1, RESP_OKAY);
        axi_wr(8'h0c, 32'h0, RESP_SLVERR);
        axi_rd(8'h0c, RESP_SLVERR);
        chk(rd === 32'h0, "unmapped read data");
        $display("test reset and cke done");
        for (int i = 0; i < 7; i++) begin
            op(1'b0, ra[i], 8'h00);
            chk(rd[15:8] === re[i] && rd[1] === 1'b0, "read-only value");
        end
        $display("test read-only done");
        for (int i = 0; i < 7; i++) op(1'b1, wa[i], 8'ha5 + i[7:0]);
        for (int i = 0; i < 7; i++) begin
            chk(cfg[i] === ((8'ha5 + i[7:0]) & wm[i]), "setting");
            op(1'b0, wa[i], 8'h00);
            chk(rd[15:8] === 8'h00, "write-only read");
        end
        op(1'b1, ADDR_MAKER_CODE, 8'h00);
        op(1'b0, ADDR_MAKER_CODE, 8'h00);
        chk(rd[15:8] === 8'h5a && cfg[0] === 8'ha5, "write to read-only");
        op(1'b1, ADDR_IO_CAL, CAL_INIT_CODE);
        op(1'b0, ADDR_DEVICE_INFO, 8'h00);
        chk(rd[15:8] === 8'h18, "self-test field");
        chk(ncal == 2, "calibration pulses");
        $display("test write-only done");
        for (int i = 0; i < 8; i++) begin
            op(bad[i][8], bad[i][7:0], 8'h00);
            chk(rd[1] === 1'b1, "forbidden access sent");
        end
        op(1'b0, 8'h0b, 8'h00);
        chk(rd[1] === 1'b0 && rd[15:8] === 8'h00, "reserved read");
        $display("test refusals done");
        rate <= 3'h5;
        op(1'b0, ADDR_REFRESH_RATE, 8'h00);
        chk(rd[15:8] === 8'h85, "temp flag set");
        op(1'b0, ADDR_REFRESH_RATE, 8'h00);
        chk(rd[15:8] === 8'h05, "temp flag clear");
        $display("test refresh rate done");
        op(1'b1, ADDR_SOFT_RESET, 8'h3c);
        after_reset();
        op(1'b0, ADDR_DEVICE_INFO, 8'h00);
        chk(rd[8] === 1'b0, "init status after reset write");
        rst_b <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        after_reset();
        $display("test reset write done");
        final_report();
    end
endmodule : sdram_mode_register_map_tb
`default_nettype wire
